// ---- verilog/bfx_pkg.sv ----
// Constants and types for the bit, flag, load and store execution unit.
// Assumes one 250 MHz clock, a classic Wishbone master and external memories.
// What this block does
// - Rotate right moves carry into bit 7, bit 0 into carry; Z,C,N,V,S, one cycle.
// - Bit-to-transfer copies one register bit into T, nothing else, one cycle.
// - Transfer-to-bit writes T into one register bit, no flag change, one cycle.
// - Overflow set and clear force V only, one cycle each.
// - Sign set and clear force S only, one cycle each.
// - Half carry set and clear force H only, other flags unchanged.
// - Post-increment load reads at the pointer, then adds one; two cycles, no flags.
// - Pre-decrement load subtracts one, then reads at the new pointer; two cycles.
// - Offset read uses Y or Z plus displacement, pointer kept, two cycles.
// - Offset write stores at Y or Z plus displacement, pointer kept, two cycles.
// - Post-increment store writes at the pointer, then adds one; two cycles.
// - Pre-decrement store subtracts one, then writes there; two cycles.
// - Direct read loads from the address word of the instruction; two cycles.
// - Direct write stores at the address word of the instruction; two cycles.
// - Program memory read fetches the byte at Z, optional Z increment; three cycles.
// - Push writes a register onto the stack in two cycles, flags kept.
// - Pop reads the stack top into a register in two cycles, flags kept.
// - Sleep issues in one cycle and hands over to power management.
// - Break acts only for the on-chip debug system, flags kept.
// - I/O bit set and clear reach addresses 0x00 to 0x1F, one bit only.
`default_nettype none

package bfx_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PROCESSOR_FLAG_REGISTER = 8'h08;
	localparam logic [7:0] OFS_SP = 8'h0c;
	localparam logic [7:0] OFS_RIDX = 8'h10;
	localparam logic [7:0] OFS_RDATA = 8'h14;

	localparam int ST_BUSY = 0;
	localparam int ST_SLEEP = 1;
	localparam int ST_HALT = 2;
	localparam int ST_ILL = 3;

	localparam logic [15:0] SP_RST = 16'h00ff;
	localparam logic [7:0] PROCESSOR_FLAG_REGISTER_RST = 8'h00;

	// ----------------------------------------
	// Flag positions and pointer pairs
	// ----------------------------------------
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 3;
	localparam int SR_S = 4;
	localparam int SR_H = 5;
	localparam int SR_T = 6;
	localparam logic [4:0] PTR_BASE = 5'h1a;
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;
	localparam logic [1:0] PTR_DIR = 2'h3;
	localparam logic [1:0] PM_NONE = 2'h0;
	localparam logic [1:0] PM_POST = 2'h1;
	localparam logic [1:0] PM_PRE = 2'h2;

	// ----------------------------------------
	// Execution lengths in clock cycles
	// ----------------------------------------
	localparam int CYC_SGL = 1;
	localparam int CYC_MEM = 2;
	localparam int CYC_PM = 3;
	localparam logic [1:0] LAST_SGL = 2'(CYC_SGL - 1);
	localparam logic [1:0] LAST_MEM = 2'(CYC_MEM - 1);
	localparam logic [1:0] LAST_PM = 2'(CYC_PM - 1);

	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_ROR = 4'h1, OP_SWAP = 4'h2, OP_FLAG = 4'h3,
		OP_BST = 4'h4, OP_BLD = 4'h5, OP_REGISTER_PAIR_COPY = 4'h6, OP_LDST = 4'h7,
		OP_LPM = 4'h8, OP_PUSH = 4'h9, OP_POP = 4'ha, OP_SLEEP = 4'hb,
		OP_BREAK = 4'hc, OP_IOBIT = 4'hd, OP_ILL = 4'he
	} bfx_op_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0, S_RUN = 2'h1, S_SLEEP = 2'h2, S_HALT = 2'h3
	} bfx_state_t;

	// Flag is store for memory ops, set for flag and I/O bit ops.
	typedef struct packed {
		bfx_op_t op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [2:0] bitn;
		logic flag;
		logic [1:0] ptr;
		logic [1:0] pmode;
		logic [5:0] disp;
		logic [1:0] last;
	} bfx_dec_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} bfx_dm_req_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [2:0] bitn;
		logic set;
		logic clr;
	} bfx_io_req_t;

endpackage : bfx_pkg

`default_nettype wire

// ---- verilog/bfx_exec_unit.sv ----
// Execution unit for rotate, bit transfer, flag, load, store, stack and control ops.
// Assumes async-read data memory, one-cycle program memory and a Wishbone master.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module bfx_exec_unit import bfx_pkg::*; (
	input wire logic clk_sys, // 250 MHz core clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output bfx_dm_req_t dm_req_o, // data memory request
	input wire logic [7:0] dm_rdata_i, // data memory read data of dm_req_o.addr
	output logic [14:0] pm_addr_o, // program memory word address
	input wire logic [15:0] pm_rdata_i, // program memory word, one cycle later
	output bfx_io_req_t io_req_o, // I/O bit set or clear strobe
	input wire logic dbg_en_i, // on-chip debug system attached
	input wire logic wake_i, // wake request from power management
	output logic sleep_o, // core asleep
	output logic break_o // core halted for the debugger
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	bfx_state_t state_q;
	logic [1:0] cnt_q;
	bfx_dec_t dec_q;
	logic [15:0] instr_q;
	logic [15:0] kaddr_q;
	logic [15:0] sp_q;
	logic [7:0] processor_flag_register_q;
	logic [7:0] processor_flag_register_d;
	logic [4:0] ridx_q;
	logic ill_q;
	logic sleep_q;
	logic brk_q;
	logic [7:0] rf_q [32];
	logic ack_q;
	logic [31:0] rdat_q;
	bfx_dm_req_t dm_q;
	logic [14:0] pm_addr_q;
	logic pm_hi_q;
	bfx_io_req_t io_q;

	logic busy;
	logic run0;
	logic run_last;
	logic [7:0] rd_val;
	logic sel_bit;
	logic rd_lsb;
	logic [4:0] ptr_lo;
	logic [15:0] ptr_val;
	logic [15:0] ptr_new;
	logic [15:0] eff;
	logic [7:0] ror_res;
	logic wa_en;
	logic [4:0] wa_idx;
	logic [7:0] wa_dat;
	logic wp_en;
	logic [4:0] wp_idx;
	logic [15:0] wp_dat;

	assign busy = (state_q != S_IDLE);
	assign run0 = (state_q == S_RUN) && (cnt_q == 2'h0);
	assign run_last = (state_q == S_RUN) && (cnt_q == dec_q.last);
	assign rd_val = rf_q[dec_q.rd];
	assign sel_bit = rd_val[dec_q.bitn];
	assign rd_lsb = rd_val[0];
	assign ptr_lo = 5'(PTR_BASE + {2'h0, dec_q.ptr, 1'b0});
	assign ptr_val = {rf_q[5'(ptr_lo + 5'h01)], rf_q[ptr_lo]};
	assign ror_res = {processor_flag_register_q[SR_C], rd_val[7:1]};

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	logic wb_wr;
	logic [7:0] wb_word;
	logic issue;
	logic [31:0] rd_mux;

	// A write commits at the edge where the master samples ack, so it lands exactly once.
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
	assign wb_word = {wb_adr_i[7:2], 2'b00};
	// A partial write of the instruction word could start a half-written opcode.
	assign issue = wb_wr && (wb_word == OFS_INSTR) && (wb_sel_i == 4'hf) && !busy;

	always_comb begin
		rd_mux = 32'h0;
		case (wb_word)
			OFS_INSTR: rd_mux = {kaddr_q, instr_q};
			OFS_STATUS: begin
				rd_mux[ST_BUSY] = busy;
				rd_mux[ST_SLEEP] = sleep_q;
				rd_mux[ST_HALT] = brk_q;
				rd_mux[ST_ILL] = ill_q;
			end
			OFS_PROCESSOR_FLAG_REGISTER: rd_mux[7:0] = processor_flag_register_q;
			OFS_SP: rd_mux[15:0] = sp_q;
			OFS_RIDX: rd_mux[4:0] = ridx_q;
			OFS_RDATA: rd_mux[7:0] = rf_q[ridx_q];
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			rdat_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ridx_q <= 5'h00;
		end else if (wb_wr && wb_word == OFS_RIDX && wb_sel_i[0]) begin
			ridx_q <= wb_dat_i[4:0];
		end
	end

	// ----------------------------------------
	// Decoder
	// ----------------------------------------
	function automatic bfx_dec_t decode(input logic [15:0] ir);
		bfx_dec_t d;
		d = '0;
		d.op = OP_ILL;
		d.rd = ir[8:4];
		d.bitn = ir[2:0];
		d.flag = ir[9];
		d.last = LAST_SGL;
		casez (ir)
			16'b0000_0000_0000_0000: d.op = OP_NOP;
			16'b1001010?????0111: d.op = OP_ROR;
			16'b1001010?????0010: d.op = OP_SWAP;
			16'b10010100????1000: begin
				d.op = OP_FLAG;
				d.flag = !ir[7];
				d.bitn = ir[6:4];
			end
			16'b1001_0101_1100_1000: begin
				d.op = OP_LPM;
				d.rd = 5'h00;
				d.ptr = PTR_Z;
				d.last = LAST_PM;
			end
			16'b1001_0101_1000_1000: d.op = OP_SLEEP;
			16'b1001_0101_1001_1000: d.op = OP_BREAK;
			16'b111110??????0???: d.op = ir[9] ? OP_BST : OP_BLD;
			16'b0000_0001_????_????: begin
				d.op = OP_REGISTER_PAIR_COPY;
				d.rd = {ir[7:4], 1'b0};
				d.rr = {ir[3:0], 1'b0};
			end
			16'b100110?0????????: begin
				d.op = OP_IOBIT;
				d.rr = ir[7:3];
				d.last = LAST_MEM;
			end
			16'b100100??????????: begin
				d.op = OP_LDST;
				d.last = LAST_MEM;
				case (ir[3:0])
					4'h0: d.ptr = PTR_DIR;
					4'hc: {d.ptr, d.pmode} = {PTR_X, PM_NONE};
					4'hd: {d.ptr, d.pmode} = {PTR_X, PM_POST};
					4'he: {d.ptr, d.pmode} = {PTR_X, PM_PRE};
					4'h9: {d.ptr, d.pmode} = {PTR_Y, PM_POST};
					4'ha: {d.ptr, d.pmode} = {PTR_Y, PM_PRE};
					4'h1: {d.ptr, d.pmode} = {PTR_Z, PM_POST};
					4'h2: {d.ptr, d.pmode} = {PTR_Z, PM_PRE};
					4'h4, 4'h5: begin
						d.op = ir[9] ? OP_ILL : OP_LPM;
						{d.ptr, d.pmode} = {PTR_Z, ir[0] ? PM_POST : PM_NONE};
						d.last = LAST_PM;
					end
					4'hf: d.op = ir[9] ? OP_PUSH : OP_POP;
					default: d.op = OP_ILL;
				endcase
			end
			16'b10?0????????????: begin
				d.op = OP_LDST;
				d.ptr = ir[3] ? PTR_Y : PTR_Z;
				d.disp = {ir[13], ir[11:10], ir[2:0]};
				d.last = LAST_MEM;
			end
			default: d.op = OP_ILL;
		endcase
		return d;
	endfunction : decode

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			cnt_q <= 2'h0;
			dec_q <= '0;
			instr_q <= 16'h0000;
			kaddr_q <= 16'h0000;
			sleep_q <= 1'b0;
			brk_q <= 1'b0;
		end else begin
			unique case (state_q)
				S_IDLE: if (issue) begin
					state_q <= S_RUN;
					cnt_q <= 2'h0;
					dec_q <= decode(wb_dat_i[15:0]);
					instr_q <= wb_dat_i[15:0];
					kaddr_q <= wb_dat_i[31:16];
				end
				S_RUN: if (run_last) begin
					if (dec_q.op == OP_SLEEP) begin
						state_q <= S_SLEEP;
						sleep_q <= 1'b1;
					end else if (dec_q.op == OP_BREAK && dbg_en_i) begin
						state_q <= S_HALT;
						brk_q <= 1'b1;
					end else begin
						state_q <= S_IDLE;
					end
				end else begin
					cnt_q <= cnt_q + 2'h1;
				end
				S_SLEEP: if (wake_i || (wb_wr && wb_word == OFS_STATUS && wb_dat_i[ST_SLEEP])) begin
					state_q <= S_IDLE;
					sleep_q <= 1'b0;
				end
				S_HALT: if (wb_wr && wb_word == OFS_STATUS && wb_dat_i[ST_HALT]) begin
					state_q <= S_IDLE;
					brk_q <= 1'b0;
				end
			endcase
		end
	end

	// Sticky bad-opcode flag; a new bad opcode wins over a clear in the same cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ill_q <= 1'b0;
		end else if (run0 && dec_q.op == OP_ILL) begin
			ill_q <= 1'b1;
		end else if (wb_wr && wb_word == OFS_STATUS && wb_dat_i[ST_ILL]) begin
			ill_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	always_comb begin
		ptr_new = (dec_q.pmode == PM_PRE) ? ptr_val - 16'h0001 : ptr_val + 16'h0001;
		if (dec_q.op == OP_PUSH) begin
			eff = sp_q;
		end else if (dec_q.op == OP_POP) begin
			eff = sp_q + 16'h0001;
		end else if (dec_q.ptr == PTR_DIR) begin
			eff = kaddr_q;
		end else if (dec_q.pmode == PM_PRE) begin
			eff = ptr_new;
		end else begin
			eff = ptr_val + {10'h000, dec_q.disp};
		end
	end

	always_comb begin
		wa_en = 1'b0;
		wa_idx = dec_q.rd;
		wa_dat = rd_val;
		wp_en = 1'b0;
		wp_idx = ptr_lo;
		wp_dat = ptr_new;
		processor_flag_register_d = processor_flag_register_q;
		if (run0) begin
			unique case (dec_q.op)
				OP_ROR: begin
					wa_en = 1'b1;
					wa_dat = ror_res;
					processor_flag_register_d[SR_C] = rd_lsb;
					processor_flag_register_d[SR_Z] = (ror_res == 8'h00);
					processor_flag_register_d[SR_N] = processor_flag_register_q[SR_C];
					processor_flag_register_d[SR_V] = processor_flag_register_q[SR_C] ^ rd_lsb;
					processor_flag_register_d[SR_S] = rd_lsb;
				end
				OP_SWAP: begin
					wa_en = 1'b1;
					wa_dat = {rd_val[3:0], rd_val[7:4]};
				end
				OP_FLAG: processor_flag_register_d[dec_q.bitn] = dec_q.flag;
				OP_BST: processor_flag_register_d[SR_T] = sel_bit;
				OP_BLD: begin
					wa_en = 1'b1;
					wa_dat[dec_q.bitn] = processor_flag_register_q[SR_T];
				end
				OP_REGISTER_PAIR_COPY: begin
					wp_en = 1'b1;
					wp_idx = dec_q.rd;
					wp_dat = {rf_q[5'(dec_q.rr + 5'h01)], rf_q[dec_q.rr]};
				end
				// Pointer moves in the first cycle; a load into the pointer itself lands later and wins.
				OP_LDST, OP_LPM: wp_en = (dec_q.pmode != PM_NONE);
				OP_NOP, OP_PUSH, OP_POP, OP_SLEEP, OP_BREAK, OP_IOBIT, OP_ILL: begin
				end
			endcase
		end
		if (run_last && cnt_q != 2'h0) begin
			if ((dec_q.op == OP_LDST && !dec_q.flag) || dec_q.op == OP_POP) begin
				wa_en = 1'b1;
				wa_dat = dm_rdata_i;
			end else if (dec_q.op == OP_LPM) begin
				wa_en = 1'b1;
				wa_dat = pm_hi_q ? pm_rdata_i[15:8] : pm_rdata_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) begin
				rf_q[i] <= 8'h00;
			end
		end else begin
			if (wb_wr && wb_word == OFS_RDATA && wb_sel_i[0] && !busy) begin
				rf_q[ridx_q] <= wb_dat_i[7:0];
			end
			if (wa_en) begin
				rf_q[wa_idx] <= wa_dat;
			end
			if (wp_en) begin
				rf_q[wp_idx] <= wp_dat[7:0];
				rf_q[5'(wp_idx + 5'h01)] <= wp_dat[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			processor_flag_register_q <= PROCESSOR_FLAG_REGISTER_RST;
		end else if (wb_wr && wb_word == OFS_PROCESSOR_FLAG_REGISTER && wb_sel_i[0] && !busy) begin
			processor_flag_register_q <= wb_dat_i[7:0];
		end else begin
			processor_flag_register_q <= processor_flag_register_d;
		end
	end

	// Stack grows downward: push writes then decrements, pop increments then reads.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sp_q <= SP_RST;
		end else if (run0 && dec_q.op == OP_PUSH) begin
			sp_q <= sp_q - 16'h0001;
		end else if (run0 && dec_q.op == OP_POP) begin
			sp_q <= sp_q + 16'h0001;
		end else if (wb_wr && wb_word == OFS_SP && !busy) begin
			if (wb_sel_i[0]) begin
				sp_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				sp_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// ----------------------------------------
	// Memory and I/O strobes
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dm_q <= '0;
			pm_addr_q <= 15'h0000;
			pm_hi_q <= 1'b0;
			io_q <= '0;
		end else if (run0) begin
			dm_q.addr <= eff;
			dm_q.wdata <= rd_val;
			dm_q.re <= (dec_q.op == OP_LDST && !dec_q.flag) || dec_q.op == OP_POP;
			dm_q.we <= (dec_q.op == OP_LDST && dec_q.flag) || dec_q.op == OP_PUSH;
			pm_addr_q <= ptr_val[15:1];
			pm_hi_q <= ptr_val[0];
			io_q.addr <= dec_q.rr;
			io_q.bitn <= dec_q.bitn;
			io_q.set <= (dec_q.op == OP_IOBIT) && dec_q.flag;
			io_q.clr <= (dec_q.op == OP_IOBIT) && !dec_q.flag;
		end else begin
			dm_q.re <= 1'b0;
			dm_q.we <= 1'b0;
			io_q.set <= 1'b0;
			io_q.clr <= 1'b0;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign dm_req_o = dm_q;
	assign pm_addr_o = pm_addr_q;
	assign io_req_o = io_q;
	assign sleep_o = sleep_q;
	assign break_o = brk_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_go(bfx_op_t o);
		run0 && dec_q.op == o;
	endsequence
	sequence s_mem_go(logic st, logic [1:0] pm);
		run0 && dec_q.op == OP_LDST && dec_q.flag == st && dec_q.pmode == pm && dec_q.ptr != PTR_DIR;
	endsequence

	property p_ror;
		s_go(OP_ROR) |=> processor_flag_register_q[SR_C] == $past(rd_lsb) && processor_flag_register_q[SR_N] == $past(processor_flag_register_q[SR_C]) && !busy;
	endproperty
	a_ror: assert property (p_ror) else $error("rotate flags wrong");
	property p_bst;
		s_go(OP_BST) |=> processor_flag_register_q[SR_T] == $past(sel_bit) && processor_flag_register_q[5:0] == $past(processor_flag_register_q[5:0]);
	endproperty
	a_bst: assert property (p_bst) else $error("bit to T wrong");
	property p_bld;
		s_go(OP_BLD) |=> processor_flag_register_q == $past(processor_flag_register_q) && !busy;
	endproperty
	a_bld: assert property (p_bld) else $error("T to bit touched flags");
	property p_flag_v;
		s_go(OP_FLAG) and (dec_q.bitn == 3'h3) |=> processor_flag_register_q[SR_V] == $past(dec_q.flag) && processor_flag_register_q[2:0] == $past(processor_flag_register_q[2:0]);
	endproperty
	a_flag_v: assert property (p_flag_v) else $error("overflow force wrong");
	property p_flag_s;
		s_go(OP_FLAG) and (dec_q.bitn == 3'h4) |=> processor_flag_register_q[SR_S] == $past(dec_q.flag) && processor_flag_register_q[3:0] == $past(processor_flag_register_q[3:0]);
	endproperty
	a_flag_s: assert property (p_flag_s) else $error("sign force wrong");
	property p_flag_h;
		s_go(OP_FLAG) and (dec_q.bitn == 3'h5) |=> processor_flag_register_q[SR_H] == $past(dec_q.flag) && processor_flag_register_q[7:6] == $past(processor_flag_register_q[7:6]);
	endproperty
	a_flag_h: assert property (p_flag_h) else $error("half carry force wrong");
	property p_ld_post;
		s_mem_go(1'b0, PM_POST) |=> dm_q.re && dm_q.addr == $past(ptr_val) && ptr_val == dm_q.addr + 16'h0001 ##1 !busy;
	endproperty
	a_ld_post: assert property (p_ld_post) else $error("post-increment load wrong");
	property p_ld_pre;
		s_mem_go(1'b0, PM_PRE) |=> dm_q.re && dm_q.addr == $past(ptr_val) - 16'h0001 ##1 !busy;
	endproperty
	a_ld_pre: assert property (p_ld_pre) else $error("pre-decrement load wrong");
	property p_disp;
		s_mem_go(dec_q.flag, PM_NONE) |=> dm_q.addr == $past(ptr_val) + {10'h000, $past(dec_q.disp)} ##1 !busy;
	endproperty
	a_disp: assert property (p_disp) else $error("displaced access wrong");
	property p_st_post;
		s_mem_go(1'b1, PM_POST) |=> dm_q.we && dm_q.wdata == $past(rd_val) && dm_q.addr == $past(ptr_val);
	endproperty
	a_st_post: assert property (p_st_post) else $error("post-increment store wrong");
	property p_st_pre;
		s_mem_go(1'b1, PM_PRE) |=> dm_q.we && dm_q.addr == $past(ptr_val) - 16'h0001 && ptr_val == dm_q.addr;
	endproperty
	a_st_pre: assert property (p_st_pre) else $error("pre-decrement store wrong");
	property p_direct;
		s_go(OP_LDST) and (dec_q.ptr == PTR_DIR) |=> (dm_q.re || dm_q.we) && dm_q.addr == kaddr_q ##1 !busy;
	endproperty
	a_direct: assert property (p_direct) else $error("direct access wrong");
	property p_lpm;
		s_go(OP_LPM) |-> busy [*3] ##1 !busy;
	endproperty
	a_lpm: assert property (p_lpm) else $error("program read not three cycles");
	property p_push;
		s_go(OP_PUSH) |=> dm_q.we && dm_q.addr == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001 ##1 !busy;
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_pop;
		s_go(OP_POP) |=> dm_q.re && dm_q.addr == sp_q && processor_flag_register_q == $past(processor_flag_register_q) ##1 !busy;
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");
	property p_sleep;
		s_go(OP_SLEEP) |=> sleep_q && state_q == S_SLEEP && processor_flag_register_q == $past(processor_flag_register_q);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	property p_break;
		s_go(OP_BREAK) |=> brk_q == $past(dbg_en_i) && processor_flag_register_q == $past(processor_flag_register_q);
	endproperty
	a_break: assert property (p_break) else $error("break misbehaved");
	property p_io;
		s_go(OP_IOBIT) |=> (io_q.set != io_q.clr) && io_q.addr == $past(dec_q.rr) ##1 !io_q.set && !io_q.clr;
	endproperty
	a_io: assert property (p_io) else $error("I/O bit strobe wrong");

endmodule : bfx_exec_unit

`default_nettype wire

// ---- dv/bfx_mem_model.sv ----
// Data and program memory standing beside the execution unit.
// Assumes async data reads and a program memory that answers one cycle late.
`timescale 1ns/1ns
`default_nettype none

module bfx_mem_model import bfx_pkg::*; (
	input wire logic clk_sys, // core clock
	input wire bfx_dm_req_t dm_req, // data memory request
	output logic [7:0] dm_rdata, // async read data
	input wire logic [14:0] pm_addr, // program word address
	output logic [15:0] pm_rdata // program word, one cycle later
);
	logic [7:0] dmem [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) dmem[i] = 8'(i) ^ 8'h5a;
	end
	// Outside a read strobe the data is inverted, so a sample taken too late is caught.
	assign dm_rdata = dm_req.re ? dmem[dm_req.addr] : ~dmem[dm_req.addr];
	always @(posedge clk_sys) begin
		if (dm_req.we) dmem[dm_req.addr] <= dm_req.wdata;
		pm_rdata <= 16'(pm_addr) ^ 16'ha55a;
	end
endmodule : bfx_mem_model

`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the execution unit, driving it over Wishbone.
// Assumes the memory model above on the far side.
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import bfx_pkg::*;
	logic clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, wake = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic ack;
	bfx_dm_req_t dm_req;
	logic [7:0] dm_rdata;
	logic [14:0] pm_addr;
	logic [15:0] pm_rdata;
	logic sleep_o, brk, dbg = 1'b0;
	bfx_io_req_t io;
	int error_cnt = 0, n_checks = 0;

	bfx_exec_unit bfx_exec_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dm_req_o(dm_req), .dm_rdata_i(dm_rdata), .pm_addr_o(pm_addr), .pm_rdata_i(pm_rdata),
		.io_req_o(io), .dbg_en_i(dbg), .wake_i(wake), .sleep_o(sleep_o), .break_o(brk));
	bfx_mem_model bfx_mem_model_i (.clk_sys(clk_sys), .dm_req(dm_req), .dm_rdata(dm_rdata),
		.pm_addr(pm_addr), .pm_rdata(pm_rdata));

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50) error_cnt++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// Starts one instruction and waits until busy clears.
	task automatic run(input logic [31:0] ins);
		int n;
		wb(1'b1, OFS_INSTR, ins);
		n = 0;
		do begin
			wb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (q[ST_BUSY] !== 1'b0 && n < 20);
		chk(q[ST_BUSY], 1'b0);
	endtask : run

	task automatic reg_is(input logic [4:0] idx, input logic [7:0] exp);
		wb(1'b1, OFS_RIDX, 32'(idx));
		wb(1'b0, OFS_RDATA, 32'h0);
		chk(q, 32'(exp));
	endtask : reg_is

	task automatic processor_flag_register_is(input logic [7:0] exp);
		wb(1'b0, OFS_PROCESSOR_FLAG_REGISTER, 32'h0);
		chk(q, 32'(exp));
	endtask : processor_flag_register_is

	task automatic t_flags;
		for (int s = SR_V; s <= SR_H; s++) begin
			run(32'h9408 | (s << 4));
			processor_flag_register_is(8'h01 << s);
			run(32'h9488 | (s << 4));
			processor_flag_register_is(8'h00);
		end
		$display("flag set and clear done");
	endtask : t_flags

	task automatic t_rotate_bits;
		run(32'h0100_9100);
		reg_is(5'd16, 8'h5a);
		run(32'h9408);
		run(32'h9507);
		reg_is(5'd16, 8'had);
		processor_flag_register_is(8'h0c);
		run(32'hfb00);
		processor_flag_register_is(8'h4c);
		run(32'hf917);
		reg_is(5'd17, 8'h80);
		processor_flag_register_is(8'h4c);
		$display("rotate and bit transfer done");
	endtask : t_rotate_bits

	task automatic t_mem;
		run(32'h0120_9310);
		chk(bfx_mem_model_i.dmem[16'h0120], 8'h80);
		run(32'h930f);
		chk(bfx_mem_model_i.dmem[16'h00ff], 8'had);
		wb(1'b0, OFS_SP, 32'h0);
		chk(q, 32'h00fe);
		run(32'h912f);
		reg_is(5'd18, 8'had);
		wb(1'b0, OFS_SP, 32'h0);
		chk(q, 32'h00ff);
		run(32'h913d);
		reg_is(5'd19, 8'h5a);
		reg_is(5'd26, 8'h01);
		run(32'h932d);
		chk(bfx_mem_model_i.dmem[16'h0001], 8'had);
		reg_is(5'd26, 8'h02);
		run(32'h914e);
		reg_is(5'd20, 8'had);
		reg_is(5'd26, 8'h01);
		run(32'h815d);
		reg_is(5'd21, 8'h5f);
		run(32'h835e);
		chk(bfx_mem_model_i.dmem[16'h0006], 8'h5f);
		reg_is(5'd28, 8'h00);
		run(32'h9165);
		reg_is(5'd22, 8'h5a);
		reg_is(5'd30, 8'h01);
		processor_flag_register_is(8'h4c);
		$display("load and store done");
	endtask : t_mem

	task automatic t_sleep;
		wb(1'b1, OFS_INSTR, 32'h9588);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(q[ST_SLEEP], 1'b1);
		chk(sleep_o, 1'b1);
		wake <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wake <= 1'b0;
		chk(sleep_o, 1'b0);
		processor_flag_register_is(8'h4c);
		wb(1'b0, 8'h1c, 32'h0);
		chk(q, 32'h0);
		$display("sleep and unmapped read done");
	endtask : t_sleep

	task automatic t_swap_copy;
		run(32'h9502);
		reg_is(5'd16, 8'hda);
		run(32'h01c9);
		reg_is(5'd24, 8'had);
		reg_is(5'd25, 8'h5a);
		processor_flag_register_is(8'h4c);
		$display("swap and pair copy done");
	endtask : t_swap_copy

	// The set or clear strobe stands for one cycle only, so it is caught as it passes.
	task automatic io_is(input logic [31:0] ins, input logic [9:0] exp);
		int n;
		wb(1'b1, OFS_INSTR, ins);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!(io.set | io.clr) && n < 10);
		chk(io, 32'(exp));
		@(posedge clk_sys);
		chk({io.set, io.clr}, 2'b00);
	endtask : io_is

	task automatic t_io_bits;
		io_is(32'h9afd, 10'h3f6);
		io_is(32'h981a, 10'h069);
		$display("I/O bit set and clear done");
	endtask : t_io_bits

	task automatic t_break;
		run(32'h9598);
		chk(brk, 1'b0);
		dbg <= 1'b1;
		wb(1'b1, OFS_INSTR, 32'h9598);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(q[ST_HALT], 1'b1);
		chk(brk, 1'b1);
		wb(1'b1, OFS_STATUS, 32'h4);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(q[3:0], 4'h0);
		chk(brk, 1'b0);
		dbg <= 1'b0;
		processor_flag_register_is(8'h4c);
		$display("break done");
	endtask : t_break

	task automatic t_bad_op;
		run(32'hffff);
		chk(q[ST_ILL], 1'b1);
		wb(1'b1, OFS_STATUS, 32'h8);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(q[ST_ILL], 1'b0);
		processor_flag_register_is(8'h4c);
		$display("bad opcode done");
	endtask : t_bad_op

	initial begin
		#100000;
		error_cnt++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_flags();
		t_rotate_bits();
		t_mem();
		t_sleep();
		t_swap_copy();
		t_io_bits();
		t_break();
		t_bad_op();
		test_done();
	end
endmodule : testbench

`default_nettype wire
